// ---- core/addx_pkg.sv ----
// Shared constants, register map and types of the add execution block.
package addx_pkg;
    // Register byte offsets on the APB slave.
    localparam logic [11:0] REG_CTRL  = 12'h000;
    localparam logic [11:0] REG_INSN  = 12'h004;
    localparam logic [11:0] REG_ACC   = 12'h008;
    localparam logic [11:0] REG_STAT  = 12'h00c;
    localparam logic [11:0] REG_BANK  = 12'h010;
    localparam logic [11:0] REG_INDEX = 12'h014;
    localparam logic [11:0] REG_MSEL  = 12'h018;
    localparam logic [11:0] REG_MDATA = 12'h01c;
    localparam logic [11:0] REG_LAST  = 12'h020;

    // Control and status bit positions.
    localparam int CTRL_GO  = 0;
    localparam int CTRL_EXT = 1;
    localparam int ST_C     = 0;
    localparam int ST_HALF  = 1;
    localparam int ST_Z     = 2;
    localparam int ST_SOVF  = 3;
    localparam int ST_N     = 4;
    localparam int ST_BUSY  = 8;
    localparam int ST_ERR   = 9;

    // Opcode fields of the instruction word.
    localparam logic [7:0] OPC_LIT = 8'h0f;
    localparam logic [5:0] OPC_ADD = 6'h09;
    localparam logic [5:0] OPC_ADC = 6'h08;
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT = 8;

    // Access bank split and the banks it maps onto.
    localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
    localparam logic [3:0] ACCESS_LOW   = 4'h0;
    localparam logic [3:0] ACCESS_HIGH  = 4'hf;

    // Reset values.
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [3:0]  RST_NIB  = 4'h0;
    localparam logic [11:0] RST_ADDR = 12'h000;
    localparam logic [15:0] RST_INSN = 16'h0000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4
    } addx_phase_t;

    typedef enum logic [1:0] {
        K_LIT, K_ADD, K_ADC
    } addx_kind_t;
endpackage

// ---- core/addx_adder.sv ----
// Eight-bit adder with carry in and the five arithmetic flags.
`timescale 1ns/10ps
module addx_adder (
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       cin,
    output logic      [7:0] sum,
    output logic            c,
    output logic            hcy,
    output logic            sov,
    output logic            n,
    output logic            z
);
    logic [8:0] full;
    logic [4:0] low;

    // Half carry comes from a separate nibble sum, not from the full sum.
    always_comb begin
        full = {1'h0, a} + {1'h0, b} + {8'h00, cin};
        low  = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, cin};
        sum  = full[7:0];
        c    = full[8];
        hcy  = low[4];
        sov  = (a[7] == b[7]) && (full[7] != a[7]); // Signed overflow.
        n    = full[7];
        z    = (full[7:0] == 8'h00);
    end
endmodule

// ---- core/addx_core.sv ----
// APB-controlled execution datapath of the three add instructions.
//
// Operation
// - Literal add: accumulator plus low byte into accumulator, five flags updated.
// - Add accumulator to file register, all five arithmetic flags updated.
// - Add with carry: accumulator, file register and carry flag summed.
// - Destination bit zero writes accumulator, one writes the file register.
// - Bank bit zero uses access bank, one uses bank_pointer bank.
// - Bank bit zero, extended set, address up to 95: indexed offset.
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
module addx_core #(
    parameter int MEM_AW = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    localparam int DEPTH = 1 << MEM_AW;

    addx_pkg::addx_phase_t phase_q, phase_d;
    addx_pkg::addx_kind_t  kind_q, kind_d;
    logic [15:0]       insn_q, insn_d;
    logic [7:0]        acc_q, acc_d;
    logic [4:0]        flag_q, flag_d;
    logic [3:0]        bank_q, bank_d;
    logic [11:0]       index_q, index_d;
    logic [11:0]       addr_q, addr_d;
    logic [MEM_AW-1:0] msel_q, msel_d;
    logic              ext_q, ext_d;
    logic              dest_q, dest_d;
    logic              err_q, err_d;
    logic [7:0]        opnd_q, opnd_d;
    logic [7:0]        res_q, res_d;
    logic [4:0]        rflag_q, rflag_d;
    logic [7:0]        mem_q [DEPTH];
    logic [7:0]        mem_d [DEPTH];
    logic [31:0]       prdata_d;
    logic              pready_d, pslverr_d;

    logic              wr_en, busy, go, cin;
    logic [7:0]        fa;
    logic [MEM_AW-1:0] midx;
    logic [7:0]        a_sum;
    logic              a_c, a_hcy, a_sov, a_n, a_z;

    assign wr_en = psel && penable && pwrite && pready;
    assign busy  = (phase_q != addx_pkg::PH_IDLE);
    assign go    = wr_en && (paddr == addx_pkg::REG_CTRL) &&
                   pwdata[addx_pkg::CTRL_GO] && !busy;
    assign fa    = insn_q[7:0];
    assign midx  = addr_q[MEM_AW-1:0];
    // carry input: only the carry-using add feeds the carry flag in.
    assign cin   = (kind_q == addx_pkg::K_ADC) && flag_q[addx_pkg::ST_C];

    addx_adder u_addx_adder (
        .a   (acc_q),
        .b   (opnd_q),
        .cin (cin),
        .sum (a_sum),
        .c   (a_c),
        .hcy (a_hcy),
        .sov (a_sov),
        .n   (a_n),
        .z   (a_z)
    );

    // Read mux is sampled in the setup cycle so the answer comes registered.
    always_comb begin
        prdata_d  = addx_pkg::RST_WORD;
        pslverr_d = 1'h0;
        pready_d  = psel && !penable;
        unique case (paddr)
            addx_pkg::REG_CTRL:  prdata_d[addx_pkg::CTRL_EXT] = ext_q;
            addx_pkg::REG_INSN:  prdata_d[15:0] = insn_q;
            addx_pkg::REG_ACC:   prdata_d[7:0] = acc_q;
            addx_pkg::REG_STAT: begin
                prdata_d[4:0] = flag_q;
                prdata_d[addx_pkg::ST_BUSY] = busy;
                prdata_d[addx_pkg::ST_ERR]  = err_q;
            end
            addx_pkg::REG_BANK:  prdata_d[3:0] = bank_q;
            addx_pkg::REG_INDEX: prdata_d[11:0] = index_q;
            addx_pkg::REG_MSEL:  prdata_d[MEM_AW-1:0] = msel_q;
            addx_pkg::REG_MDATA: prdata_d[7:0] = mem_q[msel_q];
            addx_pkg::REG_LAST:  prdata_d[11:0] = addr_q;
            default:             pslverr_d = psel && !penable;
        endcase
    end

    // Software writes first; the sequencer below overrides them in Q4,
    // so a result that lands in the same cycle as a write is never lost.
    always_comb begin
        phase_d = phase_q;
        kind_d  = kind_q;
        insn_d  = insn_q;
        acc_d   = acc_q;
        flag_d  = flag_q;
        bank_d  = bank_q;
        index_d = index_q;
        addr_d  = addr_q;
        msel_d  = msel_q;
        ext_d   = ext_q;
        dest_d  = dest_q;
        err_d   = err_q;
        opnd_d  = opnd_q;
        res_d   = res_q;
        rflag_d = rflag_q;
        mem_d   = mem_q;
        if (wr_en) begin
            unique case (paddr)
                addx_pkg::REG_CTRL:  ext_d = pwdata[addx_pkg::CTRL_EXT];
                addx_pkg::REG_INSN:  insn_d = pwdata[15:0];
                addx_pkg::REG_ACC:   acc_d = pwdata[7:0];
                addx_pkg::REG_STAT:  flag_d = pwdata[4:0];
                addx_pkg::REG_BANK:  bank_d = pwdata[3:0];
                addx_pkg::REG_INDEX: index_d = pwdata[11:0];
                addx_pkg::REG_MSEL:  msel_d = pwdata[MEM_AW-1:0];
                addx_pkg::REG_MDATA: mem_d[msel_q] = pwdata[7:0];
                default: ;
            endcase
        end
        // phase sequence: four phases per instruction cycle.
        unique case (phase_q)
            addx_pkg::PH_IDLE: begin
                if (go) begin
                    phase_d = addx_pkg::PH_Q1;
                    err_d   = 1'h0;
                end
            end
            addx_pkg::PH_Q1: begin
                phase_d = addx_pkg::PH_Q2;
                dest_d  = insn_q[addx_pkg::DEST_BIT];
                // opcode decode: literal, file add, add with carry.
                if (insn_q[15:8] == addx_pkg::OPC_LIT) begin
                    kind_d = addx_pkg::K_LIT;
                    dest_d = 1'h0;
                end else if (insn_q[15:10] == addx_pkg::OPC_ADD) begin
                    kind_d = addx_pkg::K_ADD;
                end else if (insn_q[15:10] == addx_pkg::OPC_ADC) begin
                    kind_d = addx_pkg::K_ADC;
                end else begin
                    // Anything else is not ours: flag it and go idle; the bank select below still latches the address.
                    phase_d = addx_pkg::PH_IDLE;
                    err_d   = 1'h1;
                end
                // bank select: banked, indexed or access form of the address.
                if (insn_q[addx_pkg::BANK_BIT]) begin
                    addr_d = {bank_q, fa};
                end else if (ext_q && fa <= addx_pkg::ACCESS_LIMIT) begin
                    // indexed offset: literal offset from index base.
                    addr_d = index_q + {4'h0, fa};
                end else if (fa <= addx_pkg::ACCESS_LIMIT) begin
                    addr_d = {addx_pkg::ACCESS_LOW, fa};
                end else begin
                    addr_d = {addx_pkg::ACCESS_HIGH, fa};
                end
            end
            addx_pkg::PH_Q2: begin
                phase_d = addx_pkg::PH_Q3;
                opnd_d  = (kind_q == addx_pkg::K_LIT) ? fa : mem_q[midx];
            end
            addx_pkg::PH_Q3: begin
                phase_d = addx_pkg::PH_Q4;
                res_d   = a_sum;
                rflag_d = {a_n, a_sov, a_z, a_hcy, a_c};
            end
            addx_pkg::PH_Q4: begin
                phase_d = addx_pkg::PH_IDLE;
                // flag update: every add writes all five flags.
                flag_d  = rflag_q;
                // destination select: accumulator or file register.
                if (dest_q) begin
                    mem_d[midx] = res_q;
                end else begin
                    acc_d = res_q;
                end
            end
            default: phase_d = addx_pkg::PH_IDLE;
        endcase
    end

    // All state registers; the memory is a plain flop array.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= addx_pkg::PH_IDLE;
            kind_q  <= addx_pkg::K_LIT;
            insn_q  <= addx_pkg::RST_INSN;
            acc_q   <= addx_pkg::RST_BYTE;
            flag_q  <= 5'h00;
            bank_q  <= addx_pkg::RST_NIB;
            index_q <= addx_pkg::RST_ADDR;
            addr_q  <= addx_pkg::RST_ADDR;
            msel_q  <= '0;
            ext_q   <= 1'h0;
            dest_q  <= 1'h0;
            err_q   <= 1'h0;
            opnd_q  <= addx_pkg::RST_BYTE;
            res_q   <= addx_pkg::RST_BYTE;
            rflag_q <= 5'h00;
            prdata  <= addx_pkg::RST_WORD;
            pready  <= 1'h0;
            pslverr <= 1'h0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= addx_pkg::RST_BYTE;
            end
        end else begin
            phase_q <= phase_d;
            kind_q  <= kind_d;
            insn_q  <= insn_d;
            acc_q   <= acc_d;
            flag_q  <= flag_d;
            bank_q  <= bank_d;
            index_q <= index_d;
            addr_q  <= addr_d;
            msel_q  <= msel_d;
            ext_q   <= ext_d;
            dest_q  <= dest_d;
            err_q   <= err_d;
            opnd_q  <= opnd_d;
            res_q   <= res_d;
            rflag_q <= rflag_d;
            prdata  <= prdata_d;
            pready  <= pready_d;
            pslverr <= pslverr_d;
            mem_q   <= mem_d;
        end
    end

    // Helper values for the checks below.
    logic [7:0] exp_sum;
    logic       is_q1;
    assign exp_sum = acc_q + opnd_q + {7'h00, cin};
    assign is_q1   = (phase_q == addx_pkg::PH_Q1) && (kind_d != kind_q ||
                     phase_d == addx_pkg::PH_Q2);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_lit_result: assert property (
        phase_q == addx_pkg::PH_Q3 && kind_q == addx_pkg::K_LIT
        |=> ##1 acc_q == $past(exp_sum, 2))
        else $error("literal add result wrong");
    a_add_flags: assert property (
        phase_q == addx_pkg::PH_Q3 && kind_q == addx_pkg::K_ADD
        |=> ##1 flag_q == {$past(a_n, 2), $past(a_sov, 2), $past(a_z, 2),
                            $past(a_hcy, 2), $past(a_c, 2)})
        else $error("file add flags wrong");
    a_adc_carry: assert property (
        phase_q == addx_pkg::PH_Q3 && kind_q == addx_pkg::K_ADC
        |-> cin == flag_q[addx_pkg::ST_C] &&
            a_sum == acc_q + opnd_q + {7'h00, flag_q[addx_pkg::ST_C]})
        else $error("carry not added");
    a_dest_file: assert property (
        phase_q == addx_pkg::PH_Q4 && dest_q
        |=> mem_q[midx] == $past(res_q) && acc_q == $past(acc_d))
        else $error("file destination not written");
    a_bank_sel: assert property (
        phase_q == addx_pkg::PH_Q1 && insn_q[addx_pkg::BANK_BIT]
        |=> addr_q == {$past(bank_q), $past(fa)})
        else $error("banked address wrong");
    a_index_mode: assert property (
        phase_q == addx_pkg::PH_Q1 && !insn_q[addx_pkg::BANK_BIT] && ext_q
        && fa <= addx_pkg::ACCESS_LIMIT
        |=> addr_q == $past(index_q) + {4'h0, $past(fa)})
        else $error("indexed address wrong");
    a_access_high: assert property (
        phase_q == addx_pkg::PH_Q1 && !insn_q[addx_pkg::BANK_BIT]
        && fa > addx_pkg::ACCESS_LIMIT
        |=> addr_q[11:8] == addx_pkg::ACCESS_HIGH)
        else $error("access bank address wrong");
    a_four_phase: assert property (
        phase_q == addx_pkg::PH_Q1 && phase_d == addx_pkg::PH_Q2
        |=> phase_q == addx_pkg::PH_Q2 ##1 phase_q == addx_pkg::PH_Q3
        ##1 phase_q == addx_pkg::PH_Q4 ##1 phase_q == addx_pkg::PH_IDLE)
        else $error("phase sequence broken");

    c_lit_op: cover property (
        phase_q == addx_pkg::PH_Q4 && kind_q == addx_pkg::K_LIT);
    c_adc_file: cover property (
        phase_q == addx_pkg::PH_Q4 && kind_q == addx_pkg::K_ADC && dest_q);
    c_indexed: cover property (
        is_q1 && ext_q && !insn_q[addx_pkg::BANK_BIT]);
endmodule

// ---- test/add_instruction_execute_tb.sv ----
// Self-checking testbench of the add execution block over APB.
`timescale 1ns/10ps
module add_instruction_execute_tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_on;
    int          errors;
    int          comparisons;
    int          cycles;

    addx_core #(.MEM_AW(4)) u_addx_core (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    // Half period of 12.5 ns gives the 40 MHz bus clock.
    always #12.5 pclk = ~pclk;

    // A hung handshake would stall the run, so a cycle ceiling cuts it off.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; an idle edge follows so psel is never driven twice.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        check(32'(pready), 32'h0000_0000); // one-cycle answer
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    // Expected flags, sign at bit 4 down to carry at bit 0, from operands.
    function automatic logic [4:0] flags_of(input logic [7:0] a,
                                            input logic [7:0] b,
                                            input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + 9'(ci);
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci);
        return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
                h[4], s[8]};
    endfunction

    // Loads operands, runs one instruction and judges busy, accumulator, file byte, flags, file-form address and extended bit.
    task automatic exec_chk(input logic [15:0] insn, input logic [7:0] acc0,
                            input logic [7:0] mem0, input logic ci,
                            input logic [11:0] last);
        logic [31:0] r;
        logic        e;
        logic        lit;
        logic        to_f;
        logic [7:0]  b;
        logic        cy;
        logic [7:0]  s;
        lit  = (insn[15:8] == addx_pkg::OPC_LIT);
        to_f = !lit && insn[addx_pkg::DEST_BIT];
        b    = lit ? insn[7:0] : mem0;
        cy   = (insn[15:10] == addx_pkg::OPC_ADC) && ci;
        s    = acc0 + b + 8'(cy);
        wr(addx_pkg::REG_ACC, 32'(acc0));
        wr(addx_pkg::REG_MSEL, 32'(last[3:0]));
        wr(addx_pkg::REG_MDATA, 32'(mem0));
        wr(addx_pkg::REG_STAT, 32'(ci));
        wr(addx_pkg::REG_INSN, 32'(insn));
        wr(addx_pkg::REG_CTRL, {30'h0, ext_on, 1'b1});
        apb(1'b0, addx_pkg::REG_STAT, 32'h0000_0000, r, e);
        check(32'(r[addx_pkg::ST_BUSY]), 32'h0000_0001); // busy
        apb(1'b0, addx_pkg::REG_STAT, 32'h0000_0000, r, e);
        check(32'(r[addx_pkg::ST_BUSY]), 32'h0000_0000); // four phases
        apb(1'b0, addx_pkg::REG_ACC, 32'h0000_0000, r, e);
        check(r, to_f ? 32'(acc0) : 32'(s)); // accumulator
        apb(1'b0, addx_pkg::REG_MDATA, 32'h0000_0000, r, e);
        check(r, to_f ? 32'(s) : 32'(mem0)); // file byte
        apb(1'b0, addx_pkg::REG_STAT, 32'h0000_0000, r, e);
        check(32'(r[4:0]), 32'(flags_of(acc0, b, cy))); // five flags
        if (!lit) begin
            apb(1'b0, addx_pkg::REG_LAST, 32'h0000_0000, r, e);
            check(r, 32'(last)); // resolved address
        end
        apb(1'b0, addx_pkg::REG_CTRL, 32'h0000_0000, r, e);
        check(r, {30'h0, ext_on, 1'b0}); // extended set
    endtask

    // Every register reads zero out of reset; unmapped places are refused.
    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        for (int i = 0; i <= 8; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0000_0000, r, e);
            check(r, 32'h0000_0000); // idle state
        end
        wr(12'h024, 32'h0000_00ff);
        apb(1'b0, 12'h024, 32'h0000_0000, r, e);
        check({r[30:0], e}, 32'h0000_0001); // refused place
        apb(1'b0, addx_pkg::REG_ACC, 32'h0000_0000, r, e);
        check(r, 32'h0000_0000); // no side effect
    endtask

    task automatic t_literal();
        exec_chk(16'h0f15, 8'h10, 8'h33, 1'b0, 12'h000); // plain
        exec_chk(16'h0f01, 8'h7f, 8'h33, 1'b1, 12'h000); // overflow
        exec_chk(16'h0f01, 8'hff, 8'h33, 1'b0, 12'h000); // wrap zero
    endtask

    task automatic t_add_file();
        exec_chk(16'h2402, 8'h17, 8'hc2, 1'b1, 12'h002); // carry ignored
        exec_chk(16'h26a7, 8'h88, 8'h88, 1'b0, 12'hfa7); // access high
    endtask

    // add with carry through the bank pointer
    task automatic t_adc_bank();
        wr(addx_pkg::REG_BANK, 32'h0000_0003);
        exec_chk(16'h2105, 8'h4d, 8'h02, 1'b1, 12'h305); // carry in
        exec_chk(16'h233c, 8'h0f, 8'h01, 1'b0, 12'h33c); // bank select
    endtask

    // indexed offset at and past the split
    task automatic t_indexed();
        wr(addx_pkg::REG_INDEX, 32'h0000_00f3);
        ext_on = 1'b1;
        wr(addx_pkg::REG_CTRL, 32'h0000_0002);
        exec_chk(16'h265f, 8'h01, 8'h7f, 1'b0, 12'h152); // boundary
        exec_chk(16'h2060, 8'hff, 8'h00, 1'b1, 12'hf60); // above split
        ext_on = 1'b0;
        wr(addx_pkg::REG_CTRL, 32'h0000_0000);
    endtask

    // An opcode outside the three adds sets the error bit and leaves the accumulator unchanged.
    task automatic t_refuse();
        logic [31:0] r;
        logic        e;
        wr(addx_pkg::REG_ACC, 32'h0000_005a);
        wr(addx_pkg::REG_INSN, 32'h0000_0e15);
        wr(addx_pkg::REG_CTRL, 32'h0000_0001);
        apb(1'b0, addx_pkg::REG_STAT, 32'h0000_0000, r, e);
        apb(1'b0, addx_pkg::REG_STAT, 32'h0000_0000, r, e);
        check(32'(r[9:8]), 32'h0000_0002); // refused opcode
        apb(1'b0, addx_pkg::REG_ACC, 32'h0000_0000, r, e);
        check(r, 32'h0000_005a); // only adds write
    endtask

    // Reset is held for twelve edges before the first transfer.
    initial begin
        pclk        = 1'b0;
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h000;
        pwdata      = 32'h0000_0000;
        ext_on      = 1'b0;
        errors      = 0;
        comparisons = 0;
        cycles      = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_literal();
        t_add_file();
        t_adc_bank();
        t_indexed();
        t_refuse();
        tally_and_finish();
    end
endmodule
